// *** qsm_pkg.sv ***
// constants, types and helpers shared by the cage sideband i2c switch pair
// assumes a single 20 MHz clock and a synchronous active-high reset
package qsm_pkg;

	// ****************************************************************
	// bus addresses and register layout
	// ****************************************************************
	localparam logic [6:0] SW0_ADDR        = 7'h4E;  // first port switch, 1001110
	localparam logic [6:0] SW1_ADDR        = 7'h6E;  // second port switch, 1101110
	localparam logic [6:0] FPGA_ADDR       = 7'h55;  // fpga, 1010101
	localparam int         CHAN_N          = 8;      // downstream channels per switch
	localparam logic [7:0] CTRL_RST        = 8'h00;  // all channels closed after reset
	localparam logic [2:0] FIRST_CAGE_CHAN = 3'h7;   // channel of the first cage
	localparam logic [3:0] BITS_PER_BYTE   = 4'h8;   // data bits before an ack slot
	localparam logic [1:0] TGT_NONE        = 2'h0;   // no switch addressed
	localparam logic [1:0] TGT_SW0         = 2'h1;   // first switch addressed
	localparam logic [1:0] TGT_SW1         = 2'h2;   // second switch addressed

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int         CLK_NS   = 50;   // mclk period
	localparam int         HOLD_NS  = 250;  // direction hold-off after a release
	localparam logic [2:0] HOLD_CYC = 3'((HOLD_NS + CLK_NS - 1) / CLK_NS);

	// ****************************************************************
	// types
	// ****************************************************************
	// slave states, gray steps along addr -> ack -> write -> ack
	typedef enum logic [2:0] {
		S_IDLE     = 3'h0,
		S_ADDR     = 3'h1,
		S_ADDR_ACK = 3'h3,
		S_WRITE    = 3'h2,
		S_WACK     = 3'h6,
		S_READ     = 3'h7,
		S_RACK     = 3'h5,
		S_IGNORE   = 3'h4
	} qsm_state_t;

	// one forwarded open-drain line: who currently owns the low level
	typedef struct packed {
		logic       drv_dn;  // upstream low copied onto the cages
		logic       drv_up;  // cage low copied onto the upstream bus
		logic [2:0] hold;    // blanking while our own release settles
	} qsm_line_t;

	// ****************************************************************
	// helpers
	// ****************************************************************
	// one step of the direction tracker for a forwarded line
	function automatic qsm_line_t qsm_line_step(input qsm_line_t cur,
		input logic up_low, input logic dn_low);
		qsm_line_t nx;
		nx = cur;
		if (cur.hold != 3'h0) begin
			nx.hold = cur.hold - 3'h1;
		end else if (cur.drv_dn) begin
			if (!up_low) begin
				nx.drv_dn = 1'b0;
				nx.hold   = HOLD_CYC;
			end
		end else if (cur.drv_up) begin
			if (!dn_low) begin
				nx.drv_up = 1'b0;
				nx.hold   = HOLD_CYC;
			end
		end else if (up_low) begin
			nx.drv_dn = 1'b1;
		end else if (dn_low) begin
			nx.drv_up = 1'b1;
		end
		return nx;
	endfunction : qsm_line_step

	// bit reversal, cage k of a switch sits on channel 7-k
	function automatic logic [7:0] qsm_rev8(input logic [7:0] v);
		logic [7:0] r;
		r = 8'h00;
		for (int i = 0; i < CHAN_N; i++) begin
			r[i] = v[CHAN_N - 1 - i];
		end
		return r;
	endfunction : qsm_rev8

endpackage : qsm_pkg

// *** qsm_fwd_if.sv ***
// link between the slave engine and one switch's channel forwarder
// assumes both ends run on mclk
`timescale 1ns/10ps
`default_nettype none
interface qsm_fwd_if;
	logic       up_scl_low;   // upstream clock seen low
	logic       up_sda_low;   // upstream data seen low
	logic [7:0] chan_en;      // control register, bit n opens channel n
	logic       scl_up_req;   // a cage holds clock low
	logic       sda_up_req;   // a cage holds data low

	modport main (output up_scl_low, up_sda_low, chan_en, input scl_up_req, sda_up_req);
	modport fwd  (input up_scl_low, up_sda_low, chan_en, output scl_up_req, sda_up_req);
endinterface : qsm_fwd_if
`default_nettype wire

// *** qsm_fwd.sv ***
// one 8-channel switch fabric: copies lows between upstream and open channels
// assumes cage pins are open drain and asynchronous to mclk
`timescale 1ns/10ps
`default_nettype none
module qsm_fwd
	import qsm_pkg::*;
(
	input  wire logic       mclk_in,
	input  wire logic       reset_in,
	qsm_fwd_if.fwd          link,
	input  wire logic [7:0] cage_scl_in,
	input  wire logic [7:0] cage_sda_in,
	output logic      [7:0] cage_scl_oe_out,
	output logic      [7:0] cage_sda_oe_out
);

	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		logic [7:0] scl_s1;   // first sync stage, clock
		logic [7:0] scl_s2;   // second sync stage, clock
		logic [7:0] sda_s1;   // first sync stage, data
		logic [7:0] sda_s2;   // second sync stage, data
		qsm_line_t  scl;      // clock direction tracker
		qsm_line_t  sda;      // data direction tracker
		logic [7:0] scl_oe;   // per channel clock pull
		logic [7:0] sda_oe;   // per channel data pull
	} qsm_fwd_st_t;

	qsm_fwd_st_t st;        // registered state
	qsm_fwd_st_t next_st;   // next state
	logic        scl_dn_low;  // an open cage pulls clock low
	logic        sda_dn_low;  // an open cage pulls data low

	// closed channels are invisible: their lows never reach upstream
	assign scl_dn_low = |(link.chan_en & ~st.scl_s2);
	assign sda_dn_low = |(link.chan_en & ~st.sda_s2);

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		next_st        = st;
		next_st.scl_s1 = cage_scl_in;
		next_st.scl_s2 = st.scl_s1;
		next_st.sda_s1 = cage_sda_in;
		next_st.sda_s2 = st.sda_s1;
		// forwarding follows the control register on every cycle
		next_st.scl    = qsm_line_step(st.scl, link.up_scl_low, scl_dn_low);
		next_st.sda    = qsm_line_step(st.sda, link.up_sda_low, sda_dn_low);
		next_st.scl_oe = link.chan_en & {CHAN_N{next_st.scl.drv_dn}};
		next_st.sda_oe = link.chan_en & {CHAN_N{next_st.sda.drv_dn}};
	end

	// register, sync stages released high so nothing looks pulled
	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			st <= '{scl_s1: 8'hFF, scl_s2: 8'hFF, sda_s1: 8'hFF, sda_s2: 8'hFF,
				scl: '0, sda: '0, scl_oe: 8'h00, sda_oe: 8'h00};
		end else begin
			st <= next_st;
		end
	end

	assign link.scl_up_req = st.scl.drv_up;
	assign link.sda_up_req = st.sda.drv_up;
	assign cage_scl_oe_out = st.scl_oe;
	assign cage_sda_oe_out = st.sda_oe;

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking @(posedge mclk_in); endclocking
	default disable iff (reset_in);

	property p_fwd_take;
		(st.sda == '0) && link.up_sda_low && (link.chan_en != 8'h00)
			|=> st.sda.drv_dn && (st.sda_oe == $past(link.chan_en));
	endproperty
	a_fwd_take: assert property (p_fwd_take) else $error("low not forwarded");

	property p_fwd_release;
		st.sda.drv_dn && (st.sda.hold == 3'h0) && !link.up_sda_low
			|=> !st.sda.drv_dn ##1 (st.sda.hold == HOLD_CYC - 3'h1);
	endproperty
	a_fwd_release: assert property (p_fwd_release) else $error("bad release");

	property p_fwd_closed;
		(link.chan_en == 8'h00) |=> (st.sda_oe == 8'h00) && (st.scl_oe == 8'h00);
	endproperty
	a_fwd_closed: assert property (p_fwd_closed) else $error("closed channel driven");

endmodule : qsm_fwd
`default_nettype wire

// *** qsm_sideband_mux.sv ***
// slave engine for the two cage port switches on the management i2c bus
// assumes the upstream bus pins are open drain and asynchronous to mclk
//
// Overview of operation
// - one bus reaches switches, fpga and eeprom
// - addresses: fpga 1010101, switches 1001110, 1101110
// - sixteen cages over two 8-channel switches
// - first cage on channel 7, first switch
// - open channel forwards later bus traffic
`timescale 1ns/10ps
`default_nettype none
module qsm_sideband_mux
	import qsm_pkg::*;
(
	input  wire logic        mclk_in,
	input  wire logic        reset_in,
	input  wire logic        bus_scl_in,
	output logic             bus_scl_out,
	output logic             bus_scl_oe_out,
	input  wire logic        bus_sda_in,
	output logic             bus_sda_out,
	output logic             bus_sda_oe_out,
	input  wire logic [15:0] cage_scl_in,
	output logic      [15:0] cage_scl_out,
	output logic      [15:0] cage_scl_oe_out,
	input  wire logic [15:0] cage_sda_in,
	output logic      [15:0] cage_sda_out,
	output logic      [15:0] cage_sda_oe_out,
	output logic      [7:0]  sw0_ctrl_out,
	output logic      [7:0]  sw1_ctrl_out,
	output logic             fpga_sel_out
);

	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		logic       scl_s1;   // first sync stage, clock
		logic       scl_s2;   // second sync stage, clock
		logic       scl_s3;   // previous clock, for edges
		logic       sda_s1;   // first sync stage, data
		logic       sda_s2;   // second sync stage, data
		logic       sda_s3;   // previous data, for start and stop
		qsm_state_t state;    // slave state
		logic [3:0] bit_cnt;  // bits of the current byte
		logic [7:0] shift;    // byte being shifted
		logic       rw;       // read bit of the address byte
		logic [1:0] target;   // which switch is addressed
		logic [7:0] ctrl0;    // first switch control
		logic [7:0] ctrl1;    // second switch control
		logic       drive;    // slave pulls data low
		logic       scl_oe;   // upstream clock pull
		logic       sda_oe;   // upstream data pull
		logic       fpga_sel; // transfer belongs to the fpga
	} qsm_main_st_t;

	qsm_main_st_t st;       // registered state
	qsm_main_st_t next_st;  // next state
	logic         scl_rise; // clock rising edge
	logic         scl_fall; // clock falling edge
	logic         start_c;  // start condition
	logic         stop_c;   // stop condition
	logic [7:0]   rd_byte;  // control of the addressed switch
	logic [7:0]   f0_scl_oe;  // first switch clock pulls, channel order
	logic [7:0]   f0_sda_oe;  // first switch data pulls, channel order
	logic [7:0]   f1_scl_oe;  // second switch clock pulls, channel order
	logic [7:0]   f1_sda_oe;  // second switch data pulls, channel order

	qsm_fwd_if link0 ();  // first switch fabric
	qsm_fwd_if link1 ();  // second switch fabric
	// bus conditions, all from the second sync stage onward
	assign scl_rise = st.scl_s2 && !st.scl_s3;
	assign scl_fall = !st.scl_s2 && st.scl_s3;
	assign start_c  = st.scl_s2 && st.scl_s3 && st.sda_s3 && !st.sda_s2;
	assign stop_c   = st.scl_s2 && st.scl_s3 && !st.sda_s3 && st.sda_s2;
	assign rd_byte  = (st.target == TGT_SW1) ? st.ctrl1 : st.ctrl0;

	// ****************************************************************
	// slave engine
	// ****************************************************************
	always_comb begin
		next_st        = st;
		next_st.scl_s1 = bus_scl_in;
		next_st.scl_s2 = st.scl_s1;
		next_st.scl_s3 = st.scl_s2;
		next_st.sda_s1 = bus_sda_in;
		next_st.sda_s2 = st.sda_s1;
		next_st.sda_s3 = st.sda_s2;
		if (start_c) begin
			// repeated start restarts address capture
			next_st.state    = S_ADDR;
			next_st.bit_cnt  = 4'h0;
			next_st.drive    = 1'b0;
			next_st.fpga_sel = 1'b0;
		end else if (stop_c) begin
			// the shared bus goes quiet for every target
			next_st.state    = S_IDLE;
			next_st.drive    = 1'b0;
			next_st.fpga_sel = 1'b0;
		end else begin
			case (st.state)
				S_ADDR: begin
					if (scl_rise) begin
						next_st.shift   = {st.shift[6:0], st.sda_s2};
						next_st.bit_cnt = st.bit_cnt + 4'h1;
					end else if (scl_fall && st.bit_cnt == BITS_PER_BYTE) begin
						next_st.rw = st.shift[0];
						if (st.shift[7:1] == SW0_ADDR) begin
							next_st.target = TGT_SW0;
							next_st.state  = S_ADDR_ACK;
							next_st.drive  = 1'b1;
						end else if (st.shift[7:1] == SW1_ADDR) begin
							next_st.target = TGT_SW1;
							next_st.state  = S_ADDR_ACK;
							next_st.drive  = 1'b1;
						end else begin
							// fpga and eeprom answer for themselves on the same wires
							next_st.target   = TGT_NONE;
							next_st.state    = S_IGNORE;
							next_st.fpga_sel = (st.shift[7:1] == FPGA_ADDR);
						end
					end
				end
				S_ADDR_ACK: begin
					if (scl_fall) begin
						next_st.bit_cnt = 4'h0;
						if (st.rw) begin
							next_st.state = S_READ;
							next_st.shift = rd_byte;
							next_st.drive = !rd_byte[7];
						end else begin
							next_st.state = S_WRITE;
							next_st.drive = 1'b0;
						end
					end
				end
				S_WRITE: begin
					if (scl_rise) begin
						next_st.shift   = {st.shift[6:0], st.sda_s2};
						next_st.bit_cnt = st.bit_cnt + 4'h1;
					end else if (scl_fall && st.bit_cnt == BITS_PER_BYTE) begin
						// a single byte replaces all eight enables at once
						if (st.target == TGT_SW0) begin
							next_st.ctrl0 = st.shift;
						end else begin
							next_st.ctrl1 = st.shift;
						end
						next_st.state = S_WACK;
						next_st.drive = 1'b1;
					end
				end
				S_WACK: begin
					// further bytes overwrite the register again
					if (scl_fall) begin
						next_st.state   = S_WRITE;
						next_st.drive   = 1'b0;
						next_st.bit_cnt = 4'h0;
					end
				end
				S_READ: begin
					if (scl_rise) begin
						next_st.bit_cnt = st.bit_cnt + 4'h1;
					end else if (scl_fall) begin
						if (st.bit_cnt == BITS_PER_BYTE) begin
							next_st.state = S_RACK;
							next_st.drive = 1'b0;
						end else begin
							next_st.shift = {st.shift[6:0], 1'b0};
							next_st.drive = !st.shift[6];
						end
					end
				end
				S_RACK: begin
					if (scl_rise && st.sda_s2) begin
						next_st.state = S_IGNORE;  // host nack ends the read
					end else if (scl_fall) begin
						next_st.state   = S_READ;
						next_st.shift   = rd_byte;
						next_st.drive   = !rd_byte[7];
						next_st.bit_cnt = 4'h0;
					end
				end
				S_IGNORE, S_IDLE: begin
					next_st.drive = 1'b0;
				end
				default: begin
					next_st.state = S_IDLE;
					next_st.drive = 1'b0;
				end
			endcase
		end
		// cage lows reach the host only through an open channel
		next_st.sda_oe = next_st.drive || link0.sda_up_req || link1.sda_up_req;
		next_st.scl_oe = link0.scl_up_req || link1.scl_up_req;
	end

	// register; sync stages reset released high
	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			st <= '{scl_s1: 1'b1, scl_s2: 1'b1, scl_s3: 1'b1,
				sda_s1: 1'b1, sda_s2: 1'b1, sda_s3: 1'b1,
				state: S_IDLE, bit_cnt: 4'h0, shift: 8'h00, rw: 1'b0,
				target: TGT_NONE, ctrl0: CTRL_RST, ctrl1: CTRL_RST,
				drive: 1'b0, scl_oe: 1'b0, sda_oe: 1'b0, fpga_sel: 1'b0};
		end else begin
			st <= next_st;
		end
	end

	// ****************************************************************
	// switch fabrics and cage wiring
	// ****************************************************************
	// the upstream level includes our own ack, as a real switch would pass it
	assign link0.up_scl_low = !st.scl_s2;
	assign link0.up_sda_low = !st.sda_s2;
	assign link0.chan_en    = st.ctrl0;
	assign link1.up_scl_low = !st.scl_s2;
	assign link1.up_sda_low = !st.sda_s2;
	assign link1.chan_en    = st.ctrl1;

	qsm_fwd u_fwd0 (
		.mclk_in         (mclk_in),
		.reset_in        (reset_in),
		.link            (link0),
		.cage_scl_in     (qsm_rev8(cage_scl_in[7:0])),
		.cage_sda_in     (qsm_rev8(cage_sda_in[7:0])),
		.cage_scl_oe_out (f0_scl_oe),
		.cage_sda_oe_out (f0_sda_oe)
	);

	qsm_fwd u_fwd1 (
		.mclk_in         (mclk_in),
		.reset_in        (reset_in),
		.link            (link1),
		.cage_scl_in     (qsm_rev8(cage_scl_in[15:8])),
		.cage_sda_in     (qsm_rev8(cage_sda_in[15:8])),
		.cage_scl_oe_out (f1_scl_oe),
		.cage_sda_oe_out (f1_sda_oe)
	);

	// cage 0 is channel 7 of the first switch, cage 8 channel 7 of the second
	assign cage_scl_oe_out = {qsm_rev8(f1_scl_oe), qsm_rev8(f0_scl_oe)};
	assign cage_sda_oe_out = {qsm_rev8(f1_sda_oe), qsm_rev8(f0_sda_oe)};
	assign cage_scl_out    = 16'h0000;
	assign cage_sda_out    = 16'h0000;
	assign bus_scl_out     = 1'b0;
	assign bus_sda_out     = 1'b0;
	assign bus_scl_oe_out  = st.scl_oe;
	assign bus_sda_oe_out  = st.sda_oe;
	assign sw0_ctrl_out    = st.ctrl0;
	assign sw1_ctrl_out    = st.ctrl1;
	assign fpga_sel_out    = st.fpga_sel;

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking @(posedge mclk_in); endclocking
	default disable iff (reset_in);

	property p_sw_ack;
		!start_c && !stop_c && st.state == S_ADDR && scl_fall && st.bit_cnt == BITS_PER_BYTE
			&& (st.shift[7:1] == SW0_ADDR || st.shift[7:1] == SW1_ADDR)
			|=> bus_sda_oe_out && st.state == S_ADDR_ACK;
	endproperty
	a_sw_ack: assert property (p_sw_ack) else $error("switch address not acked");
	property p_fpga_pass;
		!start_c && !stop_c && st.state == S_ADDR && scl_fall && st.bit_cnt == BITS_PER_BYTE
			&& st.shift[7:1] == FPGA_ADDR
			|=> fpga_sel_out && !st.drive && st.state == S_IGNORE;
	endproperty
	a_fpga_pass: assert property (p_fpga_pass) else $error("fpga transfer grabbed");
	property p_ctrl_write;
		!start_c && !stop_c && st.state == S_WRITE && scl_fall && st.bit_cnt == BITS_PER_BYTE
			&& st.target == TGT_SW0
			|=> sw0_ctrl_out == $past(st.shift) && sw1_ctrl_out == $past(st.ctrl1);
	endproperty
	a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");
	property p_first_cage;
		cage_sda_oe_out[0] |-> $past(st.ctrl0[FIRST_CAGE_CHAN]);
	endproperty
	a_first_cage: assert property (p_first_cage) else $error("cage 0 off channel 7");
	// after a stop only a cage low may still hold the upstream data line
	property p_stop_idle;
		stop_c && !start_c |=> st.state == S_IDLE && !st.drive
			&& bus_sda_oe_out == ($past(link0.sda_up_req) || $past(link1.sda_up_req));
	endproperty
	a_stop_idle: assert property (p_stop_idle) else $error("stop not seen");
	property p_up_copy;
		link0.sda_up_req || link1.sda_up_req |=> bus_sda_oe_out;
	endproperty
	a_up_copy: assert property (p_up_copy) else $error("cage low not passed up");
	c_ack:   cover property (st.state == S_ADDR_ACK ##1 st.state == S_WRITE);
	c_write: cover property (st.state == S_WACK && st.target == TGT_SW1);
	c_read:  cover property (st.state == S_RACK);
	c_up:    cover property (link0.sda_up_req);

endmodule : qsm_sideband_mux
`default_nettype wire

// *** qsm_host_model.sv ***
// i2c master model standing in for the management host on the bridge bus
// assumes the bench resolves the open-drain bus level from every pull
`timescale 1ns/10ps
`default_nettype none
module qsm_host_model #(
	parameter int HALF = 8  // mclk cycles per quarter step; a bit takes three of them
) (
	input  wire logic clk_in,
	input  wire logic scl_in,
	input  wire logic sda_in,
	output var logic  scl_oe_out,
	output var logic  sda_oe_out
);
	// ****************************************************************
	// bus primitives
	// ****************************************************************
	// hub port taken as enabled: the bus is reachable from time zero
	initial begin
		scl_oe_out = 1'b0;
		sda_oe_out = 1'b0;
	end

	// all pin moves land on the falling edge, well clear of sampling
	task automatic quarter();
		repeat (HALF) @(negedge clk_in);
	endtask : quarter

	// start from idle or as a repeated start; ends with both lines low
	task automatic start_c();
		quarter();
		sda_oe_out = 1'b0;
		quarter();
		scl_oe_out = 1'b0;
		quarter();
		sda_oe_out = 1'b1;
		quarter();
		scl_oe_out = 1'b1;
	endtask : start_c

	// data low, clock released, then data released while clock high
	task automatic stop_c();
		quarter();
		sda_oe_out = 1'b1;
		quarter();
		scl_oe_out = 1'b0;
		quarter();
		sda_oe_out = 1'b0;
		quarter();
	endtask : stop_c

	// one bit: data moves mid-low, sampled late in the high phase
	task automatic bit_io(input logic b, output logic r);
		int w;
		quarter();
		sda_oe_out = ~b;
		quarter();
		scl_oe_out = 1'b0;
		// bounded wait, a stretching cage may hold the clock low
		for (w = 0; w < 200 && scl_in !== 1'b1; w++) begin
			@(negedge clk_in);
		end
		quarter();
		r = sda_in;
		scl_oe_out = 1'b1;
	endtask : bit_io

	// byte msb first; ack slot always released, so a read ends in nack
	task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], q[i]);
		end
		bit_io(1'b1, ack);
	endtask : xfer
endmodule : qsm_host_model
`default_nettype wire

// *** tb_top.sv ***
// self-checking bench for the cage sideband switch pair
// assumes qsm_pkg, the design files and the host model are compiled first
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import qsm_pkg::*;
	// ****************************************************************
	// signals and bench model state
	// ****************************************************************
	logic        mclk_in;      // 20 MHz
	logic        reset_in;     // synchronous, active high
	logic        h_scl_oe;     // host pulls clock
	logic        h_sda_oe;     // host pulls data
	logic        bus_scl_oe;   // design pulls clock
	logic        bus_sda_oe;   // design pulls data
	logic [15:0] cage_scl_oe;  // design pulls cage clocks
	logic [15:0] cage_sda_oe;  // design pulls cage data
	logic [15:0] cage_pull;    // bench plays a cage pulling data
	logic [7:0]  sw0_ctrl;     // first switch enables
	logic [7:0]  sw1_ctrl;     // second switch enables
	logic        fpga_sel;     // fpga addressed
	wire         bus_scl = ~(h_scl_oe | bus_scl_oe);       // pulled-up wire
	wire         bus_sda = ~(h_sda_oe | bus_sda_oe);       // pulled-up wire
	wire  [15:0] cage_scl = ~cage_scl_oe;                  // pulled-up wires
	wire  [15:0] cage_sda = ~(cage_sda_oe | cage_pull);    // pulled-up wires
	int          fails;        // mismatches
	int          total_checks; // comparisons made
	int          cycles;       // timeout counter
	int          exp_ctrl[2];  // modelled control bytes
	int          s;
	logic [7:0]  q;
	logic        a;

	qsm_sideband_mux qsm_sideband_mux_i (.mclk_in(mclk_in), .reset_in(reset_in),
		.bus_scl_in(bus_scl), .bus_scl_out(), .bus_scl_oe_out(bus_scl_oe),
		.bus_sda_in(bus_sda), .bus_sda_out(), .bus_sda_oe_out(bus_sda_oe),
		.cage_scl_in(cage_scl), .cage_scl_out(), .cage_scl_oe_out(cage_scl_oe),
		.cage_sda_in(cage_sda), .cage_sda_out(), .cage_sda_oe_out(cage_sda_oe),
		.sw0_ctrl_out(sw0_ctrl), .sw1_ctrl_out(sw1_ctrl), .fpga_sel_out(fpga_sel));
	qsm_host_model host_i (.clk_in(mclk_in), .scl_in(bus_scl), .sda_in(bus_sda),
		.scl_oe_out(h_scl_oe), .sda_oe_out(h_sda_oe));

	// ****************************************************************
	// clock, timeout and helpers
	// ****************************************************************
	initial begin
		mclk_in = 1'b0;
		forever #25 mclk_in = ~mclk_in;
	end

	// a hang counts as a mismatch; the run needs roughly 12k cycles
	always @(posedge mclk_in) begin
		cycles++;
		if (cycles == 80000) begin
			fails++;
			final_report();
		end
	end

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : final_report

	// cage k sits on channel 7-k of its switch
	function automatic logic [15:0] cage_mask();
		logic [15:0] m;
		for (int k = 0; k < 8; k++) begin
			m[k]     = exp_ctrl[0][7 - k];
			m[8 + k] = exp_ctrl[1][7 - k];
		end
		return m;
	endfunction : cage_mask

	// n bytes from v upward in one transfer; the last one wins
	task automatic wr_sw(input int sw, input logic [7:0] v, input int n);
		host_i.start_c();
		host_i.xfer({(sw == 1) ? SW1_ADDR : SW0_ADDR, 1'b0}, q, a);
		check("switch addr ack", a, 1'b0);
		for (int i = 0; i < n; i++) begin
			host_i.xfer(v + 8'(i), q, a);
			check("ctrl byte ack", a, 1'b0);
			exp_ctrl[sw] = v + 8'(i);
		end
		host_i.stop_c();
		check("sw0 ctrl", sw0_ctrl, 16'(exp_ctrl[0]));
		check("sw1 ctrl", sw1_ctrl, 16'(exp_ctrl[1]));
	endtask : wr_sw

	task automatic rd_sw(input int sw);
		host_i.start_c();
		host_i.xfer({(sw == 1) ? SW1_ADDR : SW0_ADDR, 1'b1}, q, a);
		check("read addr ack", a, 1'b0);
		host_i.xfer(8'hFF, q, a);
		check("ctrl readback", q, 16'(exp_ctrl[sw]));
		host_i.stop_c();
	endtask : rd_sw

	// start leaves both upstream lines low: open cages must follow
	task automatic fwd_chk();
		host_i.start_c();
		repeat (4) @(negedge mclk_in);
		check("cage data pulls", cage_sda_oe, cage_mask());
		check("cage clock pulls", cage_scl_oe, cage_mask());
		host_i.stop_c();
	endtask : fwd_chk

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		void'($urandom(89));
		reset_in  = 1'b1;
		cage_pull = 16'h0000;
		exp_ctrl  = '{0, 0};
		repeat (5) @(negedge mclk_in);
		reset_in = 1'b0;
		repeat (4) @(negedge mclk_in);
		check("reset sw0 ctrl", sw0_ctrl, CTRL_RST);
		check("reset sw1 ctrl", sw1_ctrl, CTRL_RST);
		check("reset cage pulls", cage_sda_oe | cage_scl_oe, 16'h0000);
		$display("test reset done");
		// first cage through channel 7 of the first switch
		wr_sw(0, 8'h80, 1);
		fwd_chk();
		check("first cage pulled", cage_mask(), 16'h0001);
		$display("test first cage done");
		// random enables, sometimes two bytes in one transfer
		for (int t = 0; t < 8; t++) begin
			s = $urandom_range(1, 0);
			wr_sw(s, 8'($urandom), $urandom_range(2, 1));
			rd_sw(s);
			fwd_chk();
		end
		$display("test random enables done");
		// fpga address: not answered here, flagged, data ignored
		host_i.start_c();
		host_i.xfer({FPGA_ADDR, 1'b0}, q, a);
		check("fpga addr not acked", a, 1'b1);
		check("fpga selected", fpga_sel, 1'b1);
		host_i.xfer(8'h5A, q, a);
		host_i.stop_c();
		repeat (8) @(negedge mclk_in);
		check("fpga released", fpga_sel, 1'b0);
		check("sw0 untouched", sw0_ctrl, 16'(exp_ctrl[0]));
		$display("test fpga address done");
		// cage to host path: closed channel ignored, open one passed up
		wr_sw(0, 8'h00, 1);
		wr_sw(1, 8'h01, 1);
		@(negedge mclk_in);
		cage_pull = 16'h4000;
		repeat (12) @(negedge mclk_in);
		check("closed cage ignored", bus_sda_oe, 1'b0);
		check("no clock stretch", bus_scl_oe, 1'b0);
		cage_pull = 16'h0000;
		repeat (12) @(negedge mclk_in);
		cage_pull = 16'h8000;
		repeat (12) @(negedge mclk_in);
		check("open cage passed up", bus_sda_oe, 1'b1);
		cage_pull = 16'h0000;
		repeat (20) @(negedge mclk_in);
		check("bus released", bus_sda_oe, 1'b0);
		$display("test cage to host done");
		final_report();
	end
endmodule : tb_top
`default_nettype wire
